// >>> design/mxb_defines.svh
`ifndef MXB_DEFINES_SVH
`define MXB_DEFINES_SVH
// clock output divide ratio and phase boundaries
`define MXB_PHI_DIV 4
`define MXB_PHI_HIGH_PH 2'h2
// reset synchronous hold time before reset is accepted
`define MXB_RST_MIN_CYC 8
// port reset values
`define MXB_PORT_RST 8'h00
`define MXB_DIR_RST 8'h00
// slave control port field positions
`define MXB_SC_CS_N 3
`define MXB_SC_RD_N 4
`define MXB_SC_WR_N 5
`define MXB_SC_A0 6
`define MXB_SC_RDY_N 7
`endif

// >>> design/mxb_pkg.sv
package mxb_pkg;
    typedef enum logic [1:0] {
        MXB_MODE_SINGLE = 2'h0,
        MXB_MODE_EXPAND = 2'h1,
        MXB_MODE_MICRO = 2'h2
    } mxb_mode_t;
    typedef enum logic [1:0] {
        MXB_CYC_IDLE = 2'h0,
        MXB_CYC_FETCH = 2'h1,
        MXB_CYC_READ = 2'h2,
        MXB_CYC_WRITE = 2'h3
    } mxb_cyc_t;
endpackage

// >>> design/mxb_slave_if.sv
// slave buffer link between bus top and slave buffer module
interface mxb_slave_if;
    logic en;
    logic [7:0] ibuf;
    logic ibuf_full;
    logic [7:0] obuf;
    logic obuf_full;
    logic cpu_rd;
    logic cpu_wr;
    logic [7:0] cpu_wdata;
    modport buf_side (input en, cpu_rd, cpu_wr, cpu_wdata,
        output ibuf, ibuf_full, obuf, obuf_full);
    modport top_side (output en, cpu_rd, cpu_wr, cpu_wdata,
        input ibuf, ibuf_full, obuf, obuf_full);
endinterface

// >>> design/mxb_slave_buf.sv
`include "mxb_defines.svh"
// one-byte input and output buffers between the master cpu and the core
module mxb_slave_buf (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // master cpu strobes, already decoded
    input wire logic i_m_wr,
    input wire logic i_m_rd,
    input wire logic [7:0] i_m_wdata,
    // link to core side
    mxb_slave_if.buf_side sif
);
    logic [7:0] ibuf_ff, nxt_ibuf;
    logic [7:0] obuf_ff, nxt_obuf;
    logic ifull_ff, nxt_ifull;
    logic ofull_ff, nxt_ofull;

    // a set in the same cycle as a read wins so no byte arrival is lost
    always_comb begin
        nxt_ibuf = ibuf_ff;
        nxt_ifull = ifull_ff;
        nxt_obuf = obuf_ff;
        nxt_ofull = ofull_ff;
        if (sif.en) begin
            if (sif.cpu_rd) nxt_ifull = 1'b0;
            if (i_m_wr) begin
                nxt_ibuf = i_m_wdata; // RQ10
                nxt_ifull = 1'b1;
            end
            if (i_m_rd) nxt_ofull = 1'b0;
            if (sif.cpu_wr) begin
                nxt_obuf = sif.cpu_wdata; // RQ10
                nxt_ofull = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ibuf_ff <= `MXB_PORT_RST;
            obuf_ff <= `MXB_PORT_RST;
            ifull_ff <= 1'b0;
            ofull_ff <= 1'b0;
        end else begin
            ibuf_ff <= nxt_ibuf;
            obuf_ff <= nxt_obuf;
            ifull_ff <= nxt_ifull;
            ofull_ff <= nxt_ofull;
        end
    end

    assign sif.ibuf = ibuf_ff;
    assign sif.ibuf_full = ifull_ff;
    assign sif.obuf = obuf_ff;
    assign sif.obuf_full = ofull_ff;

    a_ibuf_capture: assert property (@(posedge i_clk) disable iff (i_srst)
        sif.en && i_m_wr |=> sif.ibuf_full && sif.ibuf == $past(i_m_wdata))
        else $error("input buffer did not capture master write"); // RQ10
endmodule

// >>> design/mxb_bus_ctrl.sv
`include "mxb_defines.svh"
// Function
// RQ1: the outside system holds reset low over eight clocks to enter reset.
// RQ2: the timing output runs at the clock divided by four.
// RQ3: the fetch strobe is high through each opcode fetch cycle.
// RQ4: read/write status is high for reads and low for writes.
// RQ5: outside single-chip mode the low address goes out on the address-low port.
// RQ6: outside single-chip mode the high address goes out on the address-high port.
// RQ7: outside single-chip mode the data-bus port is the two-way data bus.
// RQ8: in slave mode the slave data port becomes the master's 8-bit data bus.
// RQ9: in slave mode the upper five slave control pins become the master's control bus.
// RQ10: one-byte input and output buffers carry data to and from the master.
// RQ11: the read strobe is low while data is read from the data bus.
// RQ12: the write strobe is low while data is written out over the data bus.
// RQ13: the peripheral reset output is high throughout reset.
// RQ14: the mode pin level picks the processor mode.
// RQ15: every general port bit has its own direction bit.
// RQ16: in single-chip mode the bus ports act only as general ports.
module mxb_bus_ctrl (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_reset_n,
    // mode pin
    input wire logic i_processor_mode_pin,
    // core bus request
    input wire logic i_core_req,
    input wire mxb_pkg::mxb_cyc_t i_core_cyc,
    input wire logic [15:0] i_core_addr,
    input wire logic [7:0] i_core_wdata,
    input wire logic i_core_slave_en,
    input wire logic i_core_ibuf_rd,
    input wire logic i_core_obuf_wr,
    input wire logic [7:0] i_core_obuf_data,
    // general port values and directions: 0 low, 1 high, 2 data, 3 slave data, 4 slave ctrl
    input wire logic [39:0] i_gp_out,
    input wire logic [39:0] i_gp_dir,
    // pin inputs
    input wire logic [7:0] i_data_bus_port,
    input wire logic [7:0] i_slave_data_port,
    input wire logic [7:0] i_slave_control_port,
    // pin outputs
    output logic [7:0] o_address_low_port,
    output logic [7:0] o_address_low_port_oe,
    output logic [7:0] o_address_high_port,
    output logic [7:0] o_address_high_port_oe,
    output logic [7:0] o_data_bus_port,
    output logic [7:0] o_data_bus_port_oe,
    output logic [7:0] o_slave_data_port,
    output logic [7:0] o_slave_data_port_oe,
    output logic [7:0] o_slave_control_port,
    output logic [7:0] o_slave_control_port_oe,
    output logic o_phi,
    output logic o_fetch_sync,
    output logic o_rd_wr_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_peripheral_reset_out,
    // core side results
    output logic [7:0] o_core_rdata,
    output logic o_core_done,
    output logic [7:0] o_core_ibuf,
    output logic o_core_ibuf_full,
    output logic o_core_obuf_full,
    output mxb_pkg::mxb_mode_t o_mode
);
    mxb_slave_if sif();

    logic [1:0] ph_ff, nxt_ph;
    logic [3:0] rcnt_ff, nxt_rcnt;
    logic inrst_ff, nxt_inrst;
    mxb_pkg::mxb_mode_t mode_ff, nxt_mode;
    mxb_pkg::mxb_cyc_t cyc_ff, nxt_cyc;
    logic [15:0] addr_ff, nxt_addr;
    logic [7:0] wdat_ff, nxt_wdat;
    logic [7:0] rdat_ff, nxt_rdat;
    logic done_ff, nxt_done;
    logic [7:0] a_lo_ff, a_lo_oe_ff, a_hi_ff, a_hi_oe_ff, d_ff, d_oe_ff;
    logic [7:0] sd_ff, sd_oe_ff, sc_ff, sc_oe_ff;
    logic phi_ff, sync_ff, rw_ff, rd_n_ff, wr_n_ff, prst_ff;
    logic m_cs, m_rd, m_wr, m_rd_q;
    logic bus_mode, slave;
    logic [7:0] sc_gp_oe;

    // pin output enable per bit from direction: output drives the port latch
    function automatic logic [7:0] gp_oe(input logic [7:0] dir);
        gp_oe = dir; // RQ15
    endfunction

    // reset qualifier: reset counts as taken after the pin stays low long enough
    always_comb begin
        nxt_rcnt = rcnt_ff;
        nxt_inrst = inrst_ff;
        if (i_reset_n) begin
            nxt_rcnt = 4'h0;
            nxt_inrst = 1'b0;
        end else if (rcnt_ff != 4'(`MXB_RST_MIN_CYC)) begin
            nxt_rcnt = rcnt_ff + 4'h1;
        end else begin
            nxt_inrst = 1'b1; // RQ1
        end
    end

    // mode follows the mode pin at each clock edge while in reset, then holds once reset ends
    always_comb begin
        nxt_mode = mode_ff;
        if (inrst_ff) begin
            nxt_mode = i_processor_mode_pin ? mxb_pkg::MXB_MODE_MICRO
                                            : mxb_pkg::MXB_MODE_SINGLE; // RQ14
        end
    end

    // bus cycle engine: one cycle per period of the timing output, four clocks
    always_comb begin
        nxt_ph = ph_ff + 2'h1; // RQ2
        nxt_cyc = cyc_ff;
        nxt_addr = addr_ff;
        nxt_wdat = wdat_ff;
        nxt_rdat = rdat_ff;
        nxt_done = 1'b0;
        if (inrst_ff) begin
            nxt_ph = 2'h0;
            nxt_cyc = mxb_pkg::MXB_CYC_IDLE;
        end else if (ph_ff == 2'h3) begin
            if (cyc_ff != mxb_pkg::MXB_CYC_IDLE) begin
                nxt_done = 1'b1;
                if (cyc_ff != mxb_pkg::MXB_CYC_WRITE) nxt_rdat = i_data_bus_port;
            end
            nxt_cyc = mxb_pkg::MXB_CYC_IDLE;
            if (i_core_req && bus_mode) begin
                nxt_cyc = i_core_cyc;
                nxt_addr = i_core_addr;
                nxt_wdat = i_core_wdata;
            end
        end
    end

    assign bus_mode = mode_ff != mxb_pkg::MXB_MODE_SINGLE;
    assign slave = i_core_slave_en;
    assign m_cs = ~i_slave_control_port[`MXB_SC_CS_N];
    assign m_rd = slave && m_cs && ~i_slave_control_port[`MXB_SC_RD_N]; // RQ9
    assign m_wr = slave && m_cs && ~i_slave_control_port[`MXB_SC_WR_N]; // RQ9
    assign sif.en = slave;
    assign sif.cpu_rd = i_core_ibuf_rd;
    assign sif.cpu_wr = i_core_obuf_wr;
    assign sif.cpu_wdata = i_core_obuf_data;
    assign sc_gp_oe = gp_oe(i_gp_dir[39:32]); // RQ15

    mxb_slave_buf u_buf (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_m_wr(m_wr && !m_rd_q),
        .i_m_rd(m_rd && !m_rd_q),
        .i_m_wdata(i_slave_data_port),
        .sif(sif)
    );

    // registered pin outputs; bus drive only outside single-chip mode
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ph_ff <= 2'h0;
            rcnt_ff <= 4'h0;
            inrst_ff <= 1'b1;
            mode_ff <= mxb_pkg::MXB_MODE_SINGLE;
            cyc_ff <= mxb_pkg::MXB_CYC_IDLE;
            addr_ff <= 16'h0000;
            wdat_ff <= `MXB_PORT_RST;
            rdat_ff <= `MXB_PORT_RST;
            done_ff <= 1'b0;
            m_rd_q <= 1'b0;
            {a_lo_ff, a_hi_ff, d_ff, sd_ff, sc_ff} <= 40'h0;
            {a_lo_oe_ff, a_hi_oe_ff, d_oe_ff, sd_oe_ff, sc_oe_ff} <= 40'h0;
            {phi_ff, sync_ff, rd_n_ff, wr_n_ff} <= 4'h3;
            rw_ff <= 1'b1;
            prst_ff <= 1'b1;
        end else begin
            ph_ff <= nxt_ph;
            rcnt_ff <= nxt_rcnt;
            inrst_ff <= nxt_inrst;
            mode_ff <= nxt_mode;
            cyc_ff <= nxt_cyc;
            addr_ff <= nxt_addr;
            wdat_ff <= nxt_wdat;
            rdat_ff <= nxt_rdat;
            done_ff <= nxt_done;
            m_rd_q <= m_rd | m_wr;
            prst_ff <= nxt_inrst; // RQ13
            phi_ff <= nxt_ph[1]; // RQ2
            sync_ff <= nxt_cyc == mxb_pkg::MXB_CYC_FETCH; // RQ3
            rw_ff <= nxt_cyc != mxb_pkg::MXB_CYC_WRITE; // RQ4
            rd_n_ff <= !((nxt_cyc == mxb_pkg::MXB_CYC_READ
                || nxt_cyc == mxb_pkg::MXB_CYC_FETCH) && nxt_ph[1]); // RQ11
            wr_n_ff <= !(nxt_cyc == mxb_pkg::MXB_CYC_WRITE && nxt_ph[1]); // RQ12
            if (bus_mode) begin
                a_lo_ff <= nxt_addr[7:0]; // RQ5
                a_lo_oe_ff <= 8'hFF;
                a_hi_ff <= nxt_addr[15:8]; // RQ6
                a_hi_oe_ff <= 8'hFF;
                d_ff <= nxt_wdat; // RQ7
                d_oe_ff <= {8{nxt_cyc == mxb_pkg::MXB_CYC_WRITE}};
            end else begin
                a_lo_ff <= i_gp_out[7:0]; // RQ16
                a_lo_oe_ff <= gp_oe(i_gp_dir[7:0]);
                a_hi_ff <= i_gp_out[15:8];
                a_hi_oe_ff <= gp_oe(i_gp_dir[15:8]);
                d_ff <= i_gp_out[23:16];
                d_oe_ff <= gp_oe(i_gp_dir[23:16]);
            end
            if (slave) begin
                sd_ff <= sif.obuf; // RQ8
                sd_oe_ff <= {8{m_rd}};
                sc_ff <= {~sif.obuf_full, 4'h0, i_gp_out[34:32]};
                // pins 6:3 listen to the master, pin 7 always drives ready
                sc_oe_ff <= {1'b1, 4'h0, sc_gp_oe[2:0]}; // RQ9
            end else begin
                sd_ff <= i_gp_out[31:24];
                sd_oe_ff <= gp_oe(i_gp_dir[31:24]);
                sc_ff <= i_gp_out[39:32];
                sc_oe_ff <= gp_oe(i_gp_dir[39:32]);
            end
        end
    end

    assign o_address_low_port = a_lo_ff;
    assign o_address_low_port_oe = a_lo_oe_ff;
    assign o_address_high_port = a_hi_ff;
    assign o_address_high_port_oe = a_hi_oe_ff;
    assign o_data_bus_port = d_ff;
    assign o_data_bus_port_oe = d_oe_ff;
    assign o_slave_data_port = sd_ff;
    assign o_slave_data_port_oe = sd_oe_ff;
    assign o_slave_control_port = sc_ff;
    assign o_slave_control_port_oe = sc_oe_ff;
    assign o_phi = phi_ff;
    assign o_fetch_sync = sync_ff;
    assign o_rd_wr_n = rw_ff;
    assign o_rd_n = rd_n_ff;
    assign o_wr_n = wr_n_ff;
    assign o_peripheral_reset_out = prst_ff;
    assign o_core_rdata = rdat_ff;
    assign o_core_done = done_ff;
    assign o_core_ibuf = sif.ibuf;
    assign o_core_ibuf_full = sif.ibuf_full;
    assign o_core_obuf_full = sif.obuf_full;
    assign o_mode = mode_ff;

    a_phi_period: assert property (@(posedge i_clk) disable iff (i_srst || inrst_ff)
        $rose(o_phi) |=> o_phi ##1 !o_phi ##1 !o_phi ##1 o_phi)
        else $error("timing output is not clock over four"); // RQ2
    a_prst_follow: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_reset_n [*8] ##1 !i_reset_n |=> o_peripheral_reset_out)
        else $error("peripheral reset low during reset"); // RQ13
    a_rw_level: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_wr_n |-> !o_rd_wr_n)
        else $error("write strobe without write status"); // RQ4
    a_strobe_excl: assert property (@(posedge i_clk) disable iff (i_srst)
        !(!o_rd_n && !o_wr_n))
        else $error("read and write strobes together"); // RQ11
    a_wr_drive: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_wr_n |-> o_data_bus_port_oe == 8'hFF)
        else $error("write strobe without data drive"); // RQ12
    a_sync_read: assert property (@(posedge i_clk) disable iff (i_srst)
        o_fetch_sync |-> o_rd_wr_n)
        else $error("fetch strobe during write"); // RQ3
    a_single_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
        mode_ff == mxb_pkg::MXB_MODE_SINGLE && $stable(mode_ff) |=>
        o_address_low_port_oe == $past(i_gp_dir[7:0]))
        else $error("bus drive in single-chip mode"); // RQ16
    a_addr_out: assert property (@(posedge i_clk) disable iff (i_srst)
        bus_mode && $stable(mode_ff) |=> o_address_high_port_oe == 8'hFF)
        else $error("high address not driven in bus mode"); // RQ6
    a_mode_pick: assert property (@(posedge i_clk) disable iff (i_srst)
        inrst_ff && i_processor_mode_pin |=> o_mode == mxb_pkg::MXB_MODE_MICRO)
        else $error("mode pin not honoured"); // RQ14
endmodule

// >>> verification/mxb_mem_model.sv
// external memory on the expansion bus, answering every read strobe at once
module mxb_mem_model (
    // device bus pins
    input wire logic i_clk,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_rd_wr_n,
    input wire logic i_sync,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_addr_oe,
    input wire logic [7:0] i_wdata,
    // read answer and what the last strobe carried
    output logic [7:0] o_rdata,
    output logic [7:0] o_seen_oe,
    output logic [15:0] o_seen_addr,
    output logic [2:0] o_seen_ctl,
    output logic [7:0] o_seen_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_ff = 8'h00;
    // released bus shows the inverse of the last byte, so stale data never matches
    assign o_rdata = (i_rd_n === 1'b0) ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A) : ~last_ff;
    // note the qualifiers while a strobe is low
    always @(posedge i_clk) begin
        if (i_rd_n === 1'b0 || i_wr_n === 1'b0) begin
            o_seen_addr <= i_addr;
            o_seen_oe <= i_addr_oe;
            o_seen_ctl <= {i_rd_wr_n, i_sync, i_rd_n};
            last_ff <= o_rdata;
        end
        if (i_wr_n === 1'b0) begin
            o_seen_wdata <= i_wdata;
        end
    end
endmodule

// >>> verification/mxb_bus_ctrl_test.sv
module mxb_bus_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_reset_n = 1'b0;
    logic i_processor_mode_pin = 1'b1;
    logic i_core_req = 1'b0;
    mxb_pkg::mxb_cyc_t i_core_cyc = mxb_pkg::MXB_CYC_IDLE;
    logic [15:0] i_core_addr = 16'h0000;
    logic [7:0] i_core_wdata = 8'h00;
    logic i_core_slave_en = 1'b0;
    logic i_core_ibuf_rd = 1'b0;
    logic i_core_obuf_wr = 1'b0;
    logic [7:0] i_core_obuf_data = 8'h00;
    logic [39:0] i_gp_out = 40'h00;
    logic [39:0] i_gp_dir = 40'h00;
    logic [7:0] i_slave_data_port = 8'h00;
    logic [7:0] i_slave_control_port = 8'hFF;
    logic [7:0] data_in, lo, lo_oe, hi, hi_oe, db, db_oe, sd, sd_oe, sc, sc_oe;
    logic [7:0] rdata, ibuf, seen_oe, seen_wdata, d;
    logic phi, sync, rw, rd_n, wr_n, prst, done, ibuf_full, obuf_full, wr;
    logic [15:0] seen_addr;
    logic [2:0] seen_ctl;
    logic [25:0] e;
    logic [25:0] q[$];
    mxb_pkg::mxb_mode_t mode;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 66;
    int n;

    mxb_bus_ctrl dut (.i_clk(i_clk), .i_srst(i_srst), .i_reset_n(i_reset_n),
        .i_processor_mode_pin(i_processor_mode_pin), .i_core_req(i_core_req),
        .i_core_cyc(i_core_cyc), .i_core_addr(i_core_addr), .i_core_wdata(i_core_wdata),
        .i_core_slave_en(i_core_slave_en), .i_core_ibuf_rd(i_core_ibuf_rd),
        .i_core_obuf_wr(i_core_obuf_wr), .i_core_obuf_data(i_core_obuf_data),
        .i_gp_out(i_gp_out), .i_gp_dir(i_gp_dir), .i_data_bus_port(data_in),
        .i_slave_data_port(i_slave_data_port), .i_slave_control_port(i_slave_control_port),
        .o_address_low_port(lo), .o_address_low_port_oe(lo_oe), .o_address_high_port(hi),
        .o_address_high_port_oe(hi_oe), .o_data_bus_port(db), .o_data_bus_port_oe(db_oe),
        .o_slave_data_port(sd), .o_slave_data_port_oe(sd_oe), .o_slave_control_port(sc),
        .o_slave_control_port_oe(sc_oe), .o_phi(phi), .o_fetch_sync(sync), .o_rd_wr_n(rw),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_peripheral_reset_out(prst), .o_core_rdata(rdata),
        .o_core_done(done), .o_core_ibuf(ibuf), .o_core_ibuf_full(ibuf_full),
        .o_core_obuf_full(obuf_full), .o_mode(mode));

    mxb_mem_model mem (.i_clk(i_clk), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_rd_wr_n(rw),
        .i_sync(sync), .i_addr({hi, lo}), .i_addr_oe(lo_oe & hi_oe), .i_wdata(db),
        .o_rdata(data_in), .o_seen_oe(seen_oe), .o_seen_addr(seen_addr),
        .o_seen_ctl(seen_ctl), .o_seen_wdata(seen_wdata));

    // free-running clock, 10 ns period
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // device reset pin held well past the minimum, mode pin set meanwhile
    task automatic do_reset(input logic m);
        i_srst <= 1'b1;
        i_reset_n <= 1'b0;
        i_processor_mode_pin <= m;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (10) @(posedge i_clk);
        check({15'h0, prst}, 16'h0001);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        check({15'h0, prst}, 16'h0000);
        check({14'h0, mode}, m ? {14'h0, mxb_pkg::MXB_MODE_MICRO} : 16'h0000);
    endtask

    // stop at the edge after the timing output rose; k counts the edges waited
    task automatic sync_phi(output int k);
        logic lp;
        lp = phi;
        @(posedge i_clk);
        k = 1;
        while (!(phi === 1'b1 && lp === 1'b0) && k < 20) begin
            lp = phi;
            @(posedge i_clk);
            k++;
        end
    endtask

    // one bus cycle per four clocks; the request is held across the taking edge
    task automatic issue(input mxb_pkg::mxb_cyc_t c);
        logic [15:0] a;
        a = 16'($random(seed));
        d = 8'($random(seed));
        q.push_back({c, a, d});
        i_core_req <= 1'b1;
        i_core_cyc <= c;
        i_core_addr <= a;
        i_core_wdata <= d;
        repeat (4) @(posedge i_clk);
    endtask

    // each completion takes the oldest note; a completion with none is a fault
    always @(posedge i_clk) begin
        if (done === 1'b1) begin
            if (q.size() == 0) begin
                check(16'h0001, 16'h0000);
            end else begin
                e = q.pop_front();
                wr = (e[25:24] == 2'h3);
                check(seen_addr, e[23:8]);
                check({8'h00, seen_oe}, 16'h00FF);
                check({13'h0, seen_ctl}, {13'h0, ~wr, e[25:24] == 2'h1, wr});
                if (wr)
                    check({8'h00, seen_wdata}, {8'h00, e[7:0]});
                else
                    check({8'h00, rdata}, {8'h00, e[15:8] ^ e[23:16] ^ 8'h5A});
            end
        end
    end

    // hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        do_reset(1'b1);
        i_gp_out <= 40'({$random(seed), $random(seed)});
        i_gp_dir <= 40'({$random(seed), $random(seed)});
        sync_phi(n);
        sync_phi(n);
        check(16'(n), 16'h0004);
        for (int i = 0; i < 12; i++) begin
            issue(mxb_pkg::mxb_cyc_t'(1 + i % 3));
        end
        i_core_req <= 1'b0;
        repeat (8) @(posedge i_clk);
        check(16'(q.size()), 16'h0000);
        // master writes a byte, core reads it, core loads a byte, master reads it
        i_core_slave_en <= 1'b1;
        d = 8'($random(seed));
        i_slave_data_port <= d;
        i_slave_control_port <= 8'hD7;
        repeat (2) @(posedge i_clk);
        i_slave_control_port <= 8'hFF;
        i_slave_data_port <= ~d;
        repeat (2) @(posedge i_clk);
        check({8'h00, ibuf}, {8'h00, d});
        check({15'h0, ibuf_full}, 16'h0001);
        i_core_ibuf_rd <= 1'b1;
        i_core_obuf_wr <= 1'b1;
        i_core_obuf_data <= ~d;
        @(posedge i_clk);
        i_core_ibuf_rd <= 1'b0;
        i_core_obuf_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
        check({13'h0, ibuf_full, obuf_full, sc[7], sc_oe[7]}, 16'h0005);
        i_slave_control_port <= 8'hE7;
        repeat (3) @(posedge i_clk);
        check({sd_oe, sd}, {8'hFF, ~d});
        i_slave_control_port <= 8'hFF;
        repeat (3) @(posedge i_clk);
        check({14'h0, obuf_full, sc[7]}, 16'h0001);
        // single-chip: requests dropped, bus ports are plain ports
        i_core_slave_en <= 1'b0;
        do_reset(1'b0);
        i_core_req <= 1'b1;
        i_core_cyc <= mxb_pkg::MXB_CYC_READ;
        repeat (12) @(posedge i_clk);
        check({lo_oe, lo & lo_oe}, {i_gp_dir[7:0], i_gp_out[7:0] & i_gp_dir[7:0]});
        check({hi_oe, hi & hi_oe}, {i_gp_dir[15:8], i_gp_out[15:8] & i_gp_dir[15:8]});
        check({db_oe, db & db_oe}, {i_gp_dir[23:16], i_gp_out[23:16] & i_gp_dir[23:16]});
        summarize();
    end
endmodule
